/* File: hw/tas_defs.vh */
// constants for the thermal alarm signalling block
`ifndef TAS_DEFS_VH
`define TAS_DEFS_VH
`define TAS_NUM_CORES   2
`define TAS_ACT_W       6
`define TAS_ACT_SYSTEM_CONTROL_INTERRUPT    0
`define TAS_ACT_SYSTEM_MANAGEMENT_INTERRUPT 1
`define TAS_ACT_MSI     2
`define TAS_ACT_SREF2X  3
`define TAS_ACT_MEMTHR  4
`define TAS_ACT_PERFTHR 5
`define TAS_EDGE_ASSERT 1'b0
`define TAS_EDGE_DEASSERT 1'b1
`define TAS_ALARM_N_RST   1'b1
`define TAS_TRIP_N_RST    1'b1
`endif

/* File: hw/tas_sync3.v */
// three-stage synchroniser; change accepted when stages two and three agree
`timescale 1ns/10ps
module tas_sync3 #(
  parameter RST_VAL = 1'b1
) (
  input  wire core_clk_i,
  input  wire arst_n_i,
  input  wire d_i,
  output reg  q_o
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1  <= RST_VAL;
      s2  <= RST_VAL;
      s3  <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        q_o <= s3;
    end
  end
endmodule

/* File: hw/tas_thermal_alarm.v */
// thermal alarm aggregation, per-sensor action launch and catastrophic trip
`timescale 1ns/10ps
`include "tas_defs.vh"
module tas_thermal_alarm #(
  parameter NC = `TAS_NUM_CORES,
  parameter NS = `TAS_NUM_CORES + 1,
  parameter AW = `TAS_ACT_W
) (
  input  wire             core_clk_i,
  input  wire             arst_n_i,
  input  wire [NC-1:0]    core_hot_i,
  input  wire             hub_hot_i,
  input  wire [NC-1:0]    core_deep_idle_i,
  input  wire             hot_alarm_n_i,
  output reg              hot_alarm_n_o,
  output reg              hot_alarm_n_oe_o,
  input  wire [NS-1:0]    act_edge_i,
  input  wire [NS*AW-1:0] act_en_i,
  output reg  [NS*AW-1:0] act_start_o,
  output reg  [NS-1:0]    sensor_alarm_o,
  input  wire             catastrophic_hot_i,
  output reg              catastrophic_trip_n_o,
  output reg              catastrophic_trip_n_oe_o,
  output reg              exec_halt_o
);
  // trip tracker states
  localparam TRIP_IDLE    = 1'b0;
  localparam TRIP_LATCHED = 1'b1;

  // common alarm view states
  localparam VIEW_CLEAR   = 1'b0;
  localparam VIEW_ACTIVE  = 1'b1;

  wire          pin_low_n;
  wire          pin_low;
  wire          cat_hot;
  wire [NC-1:0] core_contrib;
  wire          any_internal;
  wire          alarm_req;
  wire          alarm_rise;
  wire          alarm_fall;
  wire [NS-1:0] launch;
  reg           alarm_seen;
  reg           next_alarm_seen;
  reg           alarm_prev;
  reg           trip_state;
  reg           next_trip_state;
  integer       k;

  // a core counts only while awake
  function core_masked;
    input hot;
    input deep_idle;
    begin
      core_masked = hot & ~deep_idle;
    end
  endfunction

  // pick the alarm edge that starts a sensor's actions
  function edge_hit;
    input edge_sel;
    input rise;
    input fall;
    begin
      if (edge_sel == `TAS_EDGE_ASSERT)
        edge_hit = rise;
      else
        edge_hit = fall;
    end
  endfunction

  // pin idles high through its pull-up
  tas_sync3 #(
    .RST_VAL (`TAS_ALARM_N_RST)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .d_i        (hot_alarm_n_i),
    .q_o        (pin_low_n)
  );

  assign pin_low = ~pin_low_n;

  tas_sync3 #(
    .RST_VAL (1'b0)
  ) u_cat_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .d_i        (catastrophic_hot_i),
    .q_o        (cat_hot)
  );

  genvar gc;
  genvar gs;

  generate
    for (gc = 0; gc < NC; gc = gc + 1) begin : g_core
      assign core_contrib[gc] = core_masked(core_hot_i[gc],
                                            core_deep_idle_i[gc]);
    end
  endgenerate

  assign any_internal = (|core_contrib) | hub_hot_i;

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hot_alarm_n_o    <= `TAS_ALARM_N_RST;
      hot_alarm_n_oe_o <= 1'b0;
    end else begin
      hot_alarm_n_o    <= 1'b0;
      hot_alarm_n_oe_o <= any_internal;
    end
  end

  // own trip or outside pull
  // the pin also carries our own drive, so the view clears only once
  // the released pin has come back through the synchroniser
  assign alarm_req = any_internal | pin_low;

  always @* begin
    next_alarm_seen = alarm_seen;
    case (alarm_seen)
      VIEW_CLEAR: begin
        if (alarm_req)
          next_alarm_seen = VIEW_ACTIVE;
      end
      VIEW_ACTIVE: begin
        if (!alarm_req)
          next_alarm_seen = VIEW_CLEAR;
      end
      default: begin
        next_alarm_seen = VIEW_CLEAR;
      end
    endcase
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alarm_seen <= VIEW_CLEAR;
      alarm_prev <= VIEW_CLEAR;
    end else begin
      alarm_seen <= next_alarm_seen;
      alarm_prev <= alarm_seen;
    end
  end

  // view starts clear, matching the idle pin, so reset gives no edge
  assign alarm_rise = alarm_seen & ~alarm_prev;
  assign alarm_fall = ~alarm_seen & alarm_prev;

  generate
    for (gs = 0; gs < NS; gs = gs + 1) begin : g_launch
      assign launch[gs] = edge_hit(act_edge_i[gs], alarm_rise, alarm_fall);
    end
  endgenerate

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sensor_alarm_o <= {NS{1'b0}};
    end else begin
      sensor_alarm_o <= {NS{alarm_seen}};
    end
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_start_o <= {NS*AW{1'b0}};
    end else begin
      for (k = 0; k < NS; k = k + 1) begin
        act_start_o[k*AW +: AW] <= act_en_i[k*AW +: AW] & {AW{launch[k]}};
      end
    end
  end

  always @* begin
    next_trip_state = trip_state;
    case (trip_state)
      TRIP_IDLE: begin
        if (cat_hot)
          next_trip_state = TRIP_LATCHED;
      end
      TRIP_LATCHED: begin
        next_trip_state = TRIP_LATCHED;
      end
      default: begin
        next_trip_state = TRIP_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trip_state <= TRIP_IDLE;
    end else begin
      trip_state <= next_trip_state;
    end
  end

  // halt and drive trip
  // outputs follow the next state so the halt lands with the latch
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      catastrophic_trip_n_o    <= `TAS_TRIP_N_RST;
      catastrophic_trip_n_oe_o <= 1'b0;
      exec_halt_o              <= 1'b0;
    end else begin
      catastrophic_trip_n_o    <= 1'b0;
      catastrophic_trip_n_oe_o <= (next_trip_state == TRIP_LATCHED);
      exec_halt_o              <= (next_trip_state == TRIP_LATCHED);
    end
  end
endmodule

/* File: dv/tas_alarm_sva.sv */
// port assertions for the thermal alarm block
`timescale 1ns/10ps
module tas_alarm_sva #(
  parameter NC = 2,
  parameter AW = 6
) (
  input wire                 core_clk_i,
  input wire                 arst_n_i,
  input wire [NC-1:0]        core_hot_i,
  input wire                 hub_hot_i,
  input wire [NC-1:0]        core_deep_idle_i,
  input wire                 hot_alarm_n_oe_o,
  input wire [NC:0]          act_edge_i,
  input wire [(NC+1)*AW-1:0] act_en_i,
  input wire [(NC+1)*AW-1:0] act_start_o,
  input wire [NC:0]          sensor_alarm_o,
  input wire                 catastrophic_hot_i,
  input wire                 catastrophic_trip_n_o,
  input wire                 catastrophic_trip_n_oe_o,
  input wire                 exec_halt_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire hot = |(core_hot_i & ~core_deep_idle_i) | hub_hot_i;
  sequence s_cat; catastrophic_hot_i [*6]; endsequence
  property p_drv; hot |=> hot_alarm_n_oe_o; endproperty
  a_drv: assert property (p_drv) else $error("alarm not driven");
  property p_idle; !hot |=> !hot_alarm_n_oe_o; endproperty
  a_idle: assert property (p_idle) else $error("alarm driven");
  property p_view; hub_hot_i |-> ##2 &sensor_alarm_o; endproperty
  a_view: assert property (p_view) else $error("view not all");
  property p_act; $rose(sensor_alarm_o[NC]) |-> act_start_o[NC*AW +: AW]
    == (act_edge_i[NC] ? 0 : act_en_i[NC*AW +: AW]); endproperty
  a_act: assert property (p_act) else $error("bad actions");
  property p_trip; s_cat |-> catastrophic_trip_n_oe_o && exec_halt_o
    && !catastrophic_trip_n_o; endproperty
  a_trip: assert property (p_trip) else $error("no trip");
  property p_hold; exec_halt_o |=> exec_halt_o && catastrophic_trip_n_oe_o;
  endproperty
  a_hold: assert property (p_hold) else $error("trip lost");
endmodule

/* File: dv/tas_board_model.sv */
// board side of the shared hot alarm wire, pulled up
`timescale 1ns/10ps
module tas_board_model (
  input  wire pull_i,
  input  wire dev_oe_i,
  input  wire dev_n_i,
  output wire alarm_n_o
);
  assign alarm_n_o = pull_i ? 1'b0 : (dev_oe_i ? dev_n_i : 1'b1);
endmodule

/* File: dv/tb_top.sv */
// random and corner tests of the thermal alarm block
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, rst_n = 0, hub = 0, ext = 0, cat = 0;
  logic [1:0] hot = 0, idl = 0;
  logic [2:0] edg = 0;
  logic [17:0] en = 0, acc;
  wire [17:0] st;
  wire [2:0] sa;
  wire an_o, an_oe, tn_o, t_oe, halt, pin;
  int num_errors = 0, comparisons = 0;
  initial forever #25 clk = ~clk;
  tas_thermal_alarm uut (.core_clk_i(clk), .arst_n_i(rst_n),
    .core_hot_i(hot), .hub_hot_i(hub), .core_deep_idle_i(idl),
    .hot_alarm_n_i(pin), .hot_alarm_n_o(an_o), .hot_alarm_n_oe_o(an_oe),
    .act_edge_i(edg), .act_en_i(en), .act_start_o(st),
    .sensor_alarm_o(sa), .catastrophic_hot_i(cat),
    .catastrophic_trip_n_o(tn_o), .catastrophic_trip_n_oe_o(t_oe),
    .exec_halt_o(halt));
  tas_board_model brd (.pull_i(ext), .dev_oe_i(an_oe), .dev_n_i(an_o),
    .alarm_n_o(pin));
  task chk(string n, logic [17:0] e, logic [17:0] s);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task grab;
    acc = 0;
    repeat (8) begin
      cyc(1);
      acc |= st;
    end
  endtask
  task summarize;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    summarize();
  end
  initial begin
    void'($urandom(41));
    cyc(8);
    rst_n = 1;
    for (int i = 0; i < 40; i++) begin
      {hot, idl, hub} = i ? 5'($urandom) : 5'h1E;
      cyc(1);
      chk("alarm_oe", 18'(|(hot & ~idl) | hub), 18'(an_oe));
      chk("alarm_level", 18'h0, 18'(an_o));
    end
    {hot, idl, hub} = 5'h00;
    en = 18'($urandom);
    cyc(4);
    ext = 1;
    cyc(8);
    chk("ext_view", 18'h7, 18'({an_oe, sa}));
    ext = 0;
    cyc(8);
    hub = 1;
    grab();
    chk("act_on", en, acc);
    edg = 3'h7;
    hub = 0;
    grab();
    chk("act_off", en, acc);
    cat = 1;
    cyc(6);
    chk("trip", 18'h6, 18'({t_oe, halt, tn_o}));
    cat = 0;
    cyc(6);
    chk("trip_hold", 18'h6, 18'({t_oe, halt, tn_o}));
    rst_n = 0;
    cyc(2);
    chk("trip_reset", 18'h1, 18'({t_oe, halt, tn_o}));
    rst_n = 1;
    cyc(2);
    chk("trip_clear", 18'h0, 18'({t_oe, halt, tn_o}));
    summarize();
  end
endmodule
bind tas_thermal_alarm tas_alarm_sva #(.NC(NC), .AW(AW)) chk (.*);
